// File: src/slc_link_cfg.sv
// serial output link setup: registers, parameter checks, applied link state and sample framing
// Overview of operation
// - all four lanes share one parameter set
// - downconverter modes use virtual converter count
// - lane rate is M*N'*10/8*fout/L
// - fout is clock over decimation register ratio
// - quick setup write sets L, M, F
// - codes 88 and 89 give four-lane two-converter
// - K multiple of four, F-dependent minimum
// - N limits per word width, CS limit for 8-bit words only
// - status bit 7 reports serializer clock lock while the link is up, and reads 0 while the link is down
// - I to first converter, Q to second
`include "slc_map.svh"
module slc_link_cfg #(
   parameter int SAMPLE_W = 16
) (
   input  wire logic                ref_clk_in,
   input  wire logic                rst_in,
   input  wire logic [11:0]         reg_addr_in,
   input  wire logic                reg_wr_in,
   input  wire logic                reg_rd_in,
   input  wire logic [7:0]          reg_wdata_in,
   output logic      [7:0]          reg_rdata_out,
   input  wire logic                pll_lock_in,
   input  wire logic [SAMPLE_W-1:0] sample_i_in,
   input  wire logic [SAMPLE_W-1:0] sample_q_in,
   output logic      [3:0]          lane_en_out,
   output logic      [SAMPLE_W-1:0] conv0_out,
   output logic      [SAMPLE_W-1:0] conv1_out,
   output logic                     frame_valid_out,
   output logic                     link_up_out,
   output logic                     low_line_rate_out,
   output logic      [7:0]          lane_rate_mult_out
);
   if (SAMPLE_W < 8 || SAMPLE_W > 16) begin : g_width_check
      $error("slc_link_cfg: SAMPLE_W must be 8 to 16");
   end

   localparam slc_pkg::slc_state_type RST_STATE = '{
      chip_mode: `SLC_RST_CHIP_MODE, chip_decimation_ratio: `SLC_RST_DCM, lrc: `SLC_RST_LRC,
      qsetup: `SLC_RST_QSETUP, pwr: `SLC_RST_PWR, kcfg: `SLC_RST_KCFG,
      ncs: `SLC_RST_NCS, word: `SLC_RST_WORD, default: '0};

   slc_pkg::slc_state_type s_q;
   slc_pkg::slc_state_type s_d;
   slc_pkg::slc_qcfg_type  dec;
   logic [3:0]             vconv;
   logic [3:0]             m_eff;
   logic [4:0]             np;
   logic [5:0]             k_val;
   logic [4:0]             n_val;
   logic                   k_err;
   logic                   ncs_err;
   logic                   m_err;
   logic                   cfg_ok;
   logic [7:0]             status;
   logic [10:0]            prod;

   function automatic logic [10:0] lane_lg(input logic [2:0] l);
      case (l)
         3'h2:    lane_lg = 11'h001;
         3'h4:    lane_lg = 11'h002;
         default: lane_lg = 11'h000;
      endcase
   endfunction

   function automatic logic [3:0] lane_mask(input logic [2:0] l);
      case (l)
         3'h1:    lane_mask = 4'h1;
         3'h2:    lane_mask = 4'h3;
         3'h4:    lane_mask = 4'hf;
         default: lane_mask = 4'h0;
      endcase
   endfunction

   slc_qcfg_decode u_decode (
      .code_in   (s_q.qsetup),
      .word16_in (s_q.word[`SLC_BIT_WORD16]),
      .cfg_out   (dec)
   );

   always_comb begin
      // virtual converter count from chip mode and Q-ignore
      case (s_q.chip_mode[1:0])
         2'h1:    vconv = s_q.chip_mode[`SLC_BIT_QIGN] ? 4'h1 : 4'h2;
         2'h2:    vconv = s_q.chip_mode[`SLC_BIT_QIGN] ? 4'h2 : 4'h4;
         2'h3:    vconv = s_q.chip_mode[`SLC_BIT_QIGN] ? 4'h4 : 4'h8;
         default: vconv = 4'h2;
      endcase
      m_eff = (s_q.chip_mode[1:0] != 2'h0) ? vconv : dec.m;
      m_err = (s_q.chip_mode[1:0] != 2'h0) && (dec.m != vconv);
      np    = s_q.word[`SLC_BIT_WORD16] ? `SLC_NP_WIDE : `SLC_NP_NARROW;
      k_val = {1'b0, s_q.kcfg[4:0]} + 6'h01;
      n_val = s_q.ncs[4:0] + 5'h01;
      if (dec.f == 5'h01) begin
         k_err = k_val < `SLC_K_MIN_F1;
      end else if (dec.f == 5'h02) begin
         k_err = k_val < `SLC_K_MIN_F2;
      end else begin
         k_err = k_val < `SLC_K_MIN_F4;
      end
      k_err = k_err || (k_val[1:0] != 2'h0) || (k_val > `SLC_K_MAX);
      if (s_q.word[`SLC_BIT_WORD16]) begin
         ncs_err = (n_val < `SLC_N_MIN_WIDE) || (n_val > `SLC_N_MAX_WIDE);
      end else begin
         ncs_err = (n_val < `SLC_N_MIN_NARROW) || (n_val > `SLC_N_MAX_NARROW)
                   || (s_q.ncs[7:`SLC_CS_LSB] > `SLC_CS_MAX_NARROW);
      end
      cfg_ok = dec.known && !k_err && !ncs_err && !m_err;
      prod   = 11'(m_eff) * 11'(np) * `SLC_RATE_NUM;
      status = '0;
      status[`SLC_BIT_LOCK]     = s_q.lock && s_q.link_up;
      status[`SLC_BIT_K_ERR]    = k_err;
      status[`SLC_BIT_NCS_ERR]  = ncs_err;
      status[`SLC_BIT_M_ERR]    = m_err;
      status[`SLC_BIT_CODE_ERR] = !dec.known;
   end

   always_comb begin
      s_d      = s_q;
      s_d.tick = 1'b0;
      if (reg_wr_in) begin
         case (reg_addr_in)
            `SLC_OFS_CHIP_MODE: s_d.chip_mode = reg_wdata_in;
            `SLC_OFS_DCM:       s_d.chip_decimation_ratio = reg_wdata_in;
            `SLC_OFS_LRC:       s_d.lrc = reg_wdata_in;
            `SLC_OFS_QSETUP:    s_d.qsetup = reg_wdata_in;
            `SLC_OFS_PWR:       s_d.pwr = reg_wdata_in;
            `SLC_OFS_KCFG:      s_d.kcfg = reg_wdata_in;
            `SLC_OFS_NCS:       s_d.ncs = reg_wdata_in;
            `SLC_OFS_WORD:      s_d.word = reg_wdata_in;
            default:            s_d.rdata = s_q.rdata;
         endcase
      end
      if (reg_rd_in) begin
         case (reg_addr_in)
            `SLC_OFS_CHIP_MODE: s_d.rdata = s_q.chip_mode;
            `SLC_OFS_DCM:       s_d.rdata = s_q.chip_decimation_ratio;
            `SLC_OFS_LRC:       s_d.rdata = s_q.lrc;
            `SLC_OFS_STATUS:    s_d.rdata = status;
            `SLC_OFS_QSETUP:    s_d.rdata = s_q.qsetup;
            `SLC_OFS_PWR:       s_d.rdata = s_q.pwr;
            `SLC_OFS_KCFG:      s_d.rdata = s_q.kcfg;
            `SLC_OFS_NCS:       s_d.rdata = s_q.ncs;
            `SLC_OFS_WORD:      s_d.rdata = s_q.word;
            default:            s_d.rdata = 8'h00;
         endcase
      end
      s_d.lock = pll_lock_in && s_q.link_up;
      if (s_q.pwr[`SLC_BIT_PD]) begin
         // powered down: lanes quiet, samples cleared
         s_d.link_up = 1'b0;
         s_d.lane_en = 4'h0;
         s_d.conv0   = '0;
         s_d.conv1   = '0;
         s_d.div_cnt = '0;
      end else if (!s_q.link_up) begin
         if (cfg_ok) begin
            // new parameters take effect only here, at power up
            s_d.link_up  = 1'b1;
            s_d.act.l    = dec.l;
            s_d.act.m    = m_eff;
            s_d.act.f    = dec.f;
            s_d.act.np   = np;
            s_d.act.mult = 8'(prod >> (`SLC_RATE_DEN_LG + lane_lg(dec.l)));
            s_d.act.chip_decimation_ratio  = (s_q.chip_decimation_ratio == 8'h00) ? 8'h01 : s_q.chip_decimation_ratio;
            s_d.lane_en  = lane_mask(dec.l);
         end
      end else begin
         // output sample rate enable: one pulse per decimation period
         if (s_q.div_cnt >= s_q.act.chip_decimation_ratio - 8'h01) begin
            s_d.div_cnt = '0;
            s_d.tick    = 1'b1;
            s_d.conv0   = 16'(sample_i_in);
            s_d.conv1   = (s_q.act.m >= 4'h2) ? 16'(sample_q_in) : 16'h0000;
         end else begin
            s_d.div_cnt = s_q.div_cnt + 8'h01;
         end
      end
   end

   always_ff @(posedge ref_clk_in) begin
      if (rst_in) begin
         s_q <= RST_STATE;
      end else begin
         s_q <= s_d;
      end
   end

   assign reg_rdata_out      = s_q.rdata;
   assign lane_en_out        = s_q.lane_en;
   assign conv0_out          = s_q.conv0[SAMPLE_W-1:0];
   assign conv1_out          = s_q.conv1[SAMPLE_W-1:0];
   assign frame_valid_out    = s_q.tick;
   assign link_up_out        = s_q.link_up;
   assign low_line_rate_out  = s_q.lrc[`SLC_BIT_LLR];
   assign lane_rate_mult_out = s_q.act.mult;

   lanes_quiet_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
      !link_up_out |-> (lane_en_out == 4'h0) && !frame_valid_out)
      else $error("lanes active while link down");
   lane_mask_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
      link_up_out |-> lane_en_out == lane_mask(s_q.act.l))
      else $error("lane enables differ from shared lane count");
   quick_88_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
      reg_wr_in && reg_addr_in == `SLC_OFS_QSETUP && reg_wdata_in == 8'h88 && s_q.word[`SLC_BIT_WORD16]
      |=> dec.known && dec.l == 3'h4 && dec.m == 4'h2 && dec.f == 5'h01)
      else $error("code 88 did not select 4 lanes 2 converters 1 octet");
   quick_step_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
      reg_wr_in && reg_addr_in == `SLC_OFS_QSETUP |=> s_q.qsetup == $past(reg_wdata_in))
      else $error("quick setup write not taken");
   rate_88_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
      $rose(link_up_out) && s_q.act.l == 3'h4 && s_q.act.m == 4'h2 && s_q.act.np == 5'h10
      |-> lane_rate_mult_out == 8'h0a)
      else $error("lane rate multiplier wrong for four lanes two converters");
   dcm_two_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
      frame_valid_out && s_q.act.chip_decimation_ratio == 8'h02 && !s_q.pwr[0] && !(reg_wr_in && reg_addr_in == `SLC_OFS_PWR)
      |=> !frame_valid_out ##1 frame_valid_out)
      else $error("sample enable not every second cycle");
   k_f1_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
      dec.f == 5'h01 && s_q.kcfg[4:0] == 5'h0f |-> k_err)
      else $error("K of 16 accepted with one octet per frame");
   ncs_narrow_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
      !s_q.word[0] && s_q.ncs[4:0] == 5'h08 |-> ncs_err)
      else $error("N of 9 accepted with 8-bit words");
   vconv_m_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
      $rose(link_up_out) && $past(s_q.chip_mode) == 8'h03 |-> s_q.act.m == 4'h8)
      else $error("four complex downconverters did not give M of 8");
   lock_bit_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
      reg_rd_in && reg_addr_in == `SLC_OFS_STATUS && !link_up_out |=> !reg_rdata_out[7])
      else $error("lock shown while link down");
   pair_map_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
      frame_valid_out && s_q.act.m >= 4'h2 |-> conv0_out == $past(sample_i_in) && conv1_out == $past(sample_q_in))
      else $error("I or Q on wrong converter");
   apply_hold_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
      link_up_out && $past(link_up_out) |-> $stable(s_q.act))
      else $error("parameters changed while link up");
endmodule

// File: src/slc_map.svh
// register offsets, field positions, reset values and limits of the link setup block
`ifndef SLC_MAP_SVH
`define SLC_MAP_SVH
`define SLC_OFS_CHIP_MODE  12'h200
`define SLC_OFS_DCM        12'h201
`define SLC_OFS_LRC        12'h56e
`define SLC_OFS_STATUS     12'h56f
`define SLC_OFS_QSETUP     12'h570
`define SLC_OFS_PWR        12'h571
`define SLC_OFS_KCFG       12'h58b
`define SLC_OFS_NCS        12'h58c
`define SLC_OFS_WORD       12'h58d
`define SLC_RST_CHIP_MODE  8'h00
`define SLC_RST_DCM        8'h01
`define SLC_RST_LRC        8'h00
`define SLC_RST_QSETUP     8'h88
`define SLC_RST_PWR        8'h00
`define SLC_RST_KCFG       8'h1f
`define SLC_RST_NCS        8'h0d
`define SLC_RST_WORD       8'h01
`define SLC_BIT_LLR        4
`define SLC_BIT_LOCK       7
`define SLC_BIT_PD         0
`define SLC_BIT_QIGN       5
`define SLC_BIT_WORD16     0
`define SLC_BIT_K_ERR      0
`define SLC_BIT_NCS_ERR    1
`define SLC_BIT_M_ERR      2
`define SLC_BIT_CODE_ERR   3
`define SLC_CS_LSB         6
`define SLC_NP_WIDE        5'h10
`define SLC_NP_NARROW      5'h08
`define SLC_RATE_NUM       11'h00a
`define SLC_RATE_DEN_LG    11'h003
`define SLC_K_MAX          6'h20
`define SLC_K_MIN_F1       6'h14
`define SLC_K_MIN_F2       6'h0c
`define SLC_K_MIN_F4       6'h08
`define SLC_N_MIN_WIDE     5'h08
`define SLC_N_MAX_WIDE     5'h10
`define SLC_N_MIN_NARROW   5'h07
`define SLC_N_MAX_NARROW   5'h08
`define SLC_CS_MAX_NARROW  2'h1
`endif

// File: src/slc_pkg.sv
// types shared by the link setup block
package slc_pkg;
   typedef struct packed {
      logic       known;
      logic [2:0] l;
      logic [3:0] m;
      logic [4:0] f;
   } slc_qcfg_type;

   typedef struct packed {
      logic [2:0] l;
      logic [3:0] m;
      logic [4:0] f;
      logic [4:0] np;
      logic [7:0] mult;
      logic [7:0] chip_decimation_ratio;
   } slc_act_type;

   typedef struct packed {
      logic [7:0]   chip_mode;
      logic [7:0]   chip_decimation_ratio;
      logic [7:0]   lrc;
      logic [7:0]   qsetup;
      logic [7:0]   pwr;
      logic [7:0]   kcfg;
      logic [7:0]   ncs;
      logic [7:0]   word;
      slc_act_type  act;
      logic         link_up;
      logic [7:0]   div_cnt;
      logic         tick;
      logic [15:0]  conv0;
      logic [15:0]  conv1;
      logic [3:0]   lane_en;
      logic         lock;
      logic [7:0]   rdata;
   } slc_state_type;
endpackage

// File: src/slc_qcfg_decode.sv
// quick configuration code to lane, converter and octet counts
module slc_qcfg_decode (
   input  wire logic [7:0]            code_in,
   input  wire logic                  word16_in,
   output slc_pkg::slc_qcfg_type      cfg_out
);
   always_comb begin
      cfg_out = '0;
      if (word16_in) begin
         case (code_in)
            8'h01:   cfg_out = '{1'b1, 3'h1, 4'h1, 5'h02};
            8'h40:   cfg_out = '{1'b1, 3'h2, 4'h1, 5'h01};
            8'h41:   cfg_out = '{1'b1, 3'h2, 4'h1, 5'h02};
            8'h80:   cfg_out = '{1'b1, 3'h4, 4'h1, 5'h01};
            8'h81:   cfg_out = '{1'b1, 3'h4, 4'h1, 5'h02};
            8'h0a:   cfg_out = '{1'b1, 3'h1, 4'h2, 5'h04};
            8'h49:   cfg_out = '{1'b1, 3'h2, 4'h2, 5'h02};
            8'h88:   cfg_out = '{1'b1, 3'h4, 4'h2, 5'h01};
            8'h89:   cfg_out = '{1'b1, 3'h4, 4'h2, 5'h02};
            8'h13:   cfg_out = '{1'b1, 3'h1, 4'h4, 5'h08};
            8'h52:   cfg_out = '{1'b1, 3'h2, 4'h4, 5'h04};
            8'h91:   cfg_out = '{1'b1, 3'h4, 4'h4, 5'h02};
            8'h1c:   cfg_out = '{1'b1, 3'h1, 4'h8, 5'h10};
            8'h5b:   cfg_out = '{1'b1, 3'h2, 4'h8, 5'h08};
            8'h9a:   cfg_out = '{1'b1, 3'h4, 4'h8, 5'h04};
            default: cfg_out = '0;
         endcase
      end else begin
         case (code_in)
            8'h00:   cfg_out = '{1'b1, 3'h1, 4'h1, 5'h01};
            8'h01:   cfg_out = '{1'b1, 3'h1, 4'h1, 5'h02};
            8'h40:   cfg_out = '{1'b1, 3'h2, 4'h1, 5'h01};
            8'h41:   cfg_out = '{1'b1, 3'h2, 4'h1, 5'h02};
            8'h42:   cfg_out = '{1'b1, 3'h2, 4'h1, 5'h04};
            8'h80:   cfg_out = '{1'b1, 3'h4, 4'h1, 5'h01};
            8'h81:   cfg_out = '{1'b1, 3'h4, 4'h1, 5'h02};
            8'h09:   cfg_out = '{1'b1, 3'h1, 4'h2, 5'h02};
            8'h48:   cfg_out = '{1'b1, 3'h2, 4'h2, 5'h01};
            8'h49:   cfg_out = '{1'b1, 3'h2, 4'h2, 5'h02};
            8'h88:   cfg_out = '{1'b1, 3'h4, 4'h2, 5'h01};
            8'h89:   cfg_out = '{1'b1, 3'h4, 4'h2, 5'h02};
            8'h8a:   cfg_out = '{1'b1, 3'h4, 4'h2, 5'h04};
            default: cfg_out = '0;
         endcase
      end
   end
endmodule

// File: test/slc_rx_model.sv
// far-end receiver model: captures samples and frame spacing
module slc_rx_model (
   input  wire logic        clk_in,
   input  wire logic        rst_in,
   input  wire logic [3:0]  lane_en_in,
   input  wire logic [15:0] conv0_in,
   input  wire logic [15:0] conv1_in,
   input  wire logic        frame_valid_in,
   output logic      [15:0] i_out,
   output logic      [15:0] q_out,
   output int               gap_out,
   output int               stray_out
);
   timeunit 1ns;
   timeprecision 1ps;
   int cnt;
   always @(posedge clk_in) begin
      cnt <= cnt + 1;
      if (rst_in) begin
         cnt <= 0;
         gap_out <= 0;
         stray_out <= 0;
         i_out <= 16'h0000;
         q_out <= 16'h0000;
      end else if (frame_valid_in) begin
         cnt <= 1;
         gap_out <= cnt;
         // a frame with no lane active is counted as stray
         if (lane_en_in == 4'h0) stray_out <= stray_out + 1;
         else begin
            // one parameter set: any active lane carries the frame
            i_out <= conv0_in;
            q_out <= conv1_in;
         end
      end
   end
endmodule

// File: test/tb_top.sv
// self-checking bench of the link setup block
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic        ref_clk_in, rst_in, reg_wr, reg_rd, lock, fv, up, llr;
   logic [11:0] addr;
   logic [7:0]  wdata, rdata, mult, v;
   logic [15:0] si, sq, c0, c1, rx_i, rx_q;
   logic [3:0]  lanes;
   int          mismatches, total_checks, seed, gap, stray, s0, m;
   logic [11:0] ra [8] = '{12'h200, 12'h201, 12'h56e, 12'h570, 12'h571, 12'h58b, 12'h58c, 12'h58d};
   logic [7:0]  rv [8] = '{8'h00, 8'h01, 8'h00, 8'h88, 8'h00, 8'h1f, 8'h0d, 8'h01};
   logic [7:0]  qc [5] = '{8'h88, 8'h88, 8'h89, 8'h49, 8'h0a};
   int          qw [5] = '{0, 1, 1, 1, 1};
   int          ql [5] = '{4, 4, 4, 2, 1};
   int          qd [5] = '{1, 1, 2, 2, 8};
   logic [11:0] ea [4] = '{12'h570, 12'h58b, 12'h58c, 12'h200};
   logic [7:0]  eb [4] = '{8'h33, 8'h0a, 8'h05, 8'h21};
   logic [7:0]  ec [4] = '{8'h49, 8'h1f, 8'h0d, 8'h01};
   logic [7:0]  ee [4] = '{8'h08, 8'h01, 8'h02, 8'h04};

   slc_link_cfg dut (.ref_clk_in(ref_clk_in), .rst_in(rst_in), .reg_addr_in(addr), .reg_wr_in(reg_wr),
      .reg_rd_in(reg_rd), .reg_wdata_in(wdata), .reg_rdata_out(rdata), .pll_lock_in(lock),
      .sample_i_in(si), .sample_q_in(sq), .lane_en_out(lanes), .conv0_out(c0), .conv1_out(c1),
      .frame_valid_out(fv), .link_up_out(up), .low_line_rate_out(llr), .lane_rate_mult_out(mult));
   slc_rx_model rx (.clk_in(ref_clk_in), .rst_in(rst_in), .lane_en_in(lanes), .conv0_in(c0),
      .conv1_in(c1), .frame_valid_in(fv), .i_out(rx_i), .q_out(rx_q), .gap_out(gap), .stray_out(stray));

   initial begin
      ref_clk_in = 1'b0;
      forever #2.5 ref_clk_in = ~ref_clk_in;
   end

   task automatic conclude();
      $display("checks %0d mismatches %0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask

   task automatic chk(string n, logic [15:0] e, logic [15:0] s);
      total_checks++;
      if (s !== e) begin
         mismatches++;
         $display("[ERR] %s expected %h seen %h", n, e, s);
      end
   endtask

   task automatic wr(logic [11:0] a, logic [7:0] d);
      addr <= a;
      wdata <= d;
      reg_wr <= 1'b1;
      @(posedge ref_clk_in);
      reg_wr <= 1'b0;
      @(posedge ref_clk_in);
   endtask

   task automatic rd(logic [11:0] a, output logic [7:0] d);
      addr <= a;
      reg_rd <= 1'b1;
      @(posedge ref_clk_in);
      reg_rd <= 1'b0;
      @(posedge ref_clk_in);
      d = rdata;
   endtask

   // power down, pick the code and details, set low line rate for slow rates, power up
   task automatic setup(logic [7:0] code, int w, int d, int mu);
      wr(12'h571, 8'h01);
      wr(12'h58d, w ? 8'h01 : 8'h00);
      wr(12'h58c, w ? 8'h0d : 8'h07);
      wr(12'h570, code);
      wr(12'h201, d[7:0]);
      wr(12'h56e, (mu * 1000 / d < 6250) ? 8'h10 : 8'h00);
      wr(12'h571, 8'h00);
      repeat (2) @(posedge ref_clk_in);
   endtask

   initial begin
      repeat (20000) @(posedge ref_clk_in);
      mismatches++;
      conclude();
   end

   initial begin
      rst_in = 1'b1; reg_wr = 1'b0; reg_rd = 1'b0; addr = 12'h000; wdata = 8'h00; lock = 1'b1;
      si = 16'h0000; sq = 16'h0000; seed = 47; mismatches = 0; total_checks = 0;
      repeat (6) @(posedge ref_clk_in);
      chk("link_up", 16'h0000, up);
      rst_in <= 1'b0;
      repeat (3) @(posedge ref_clk_in);
      chk("link_up", 16'h0001, up);
      chk("lanes", 16'h000f, lanes);
      chk("mult", 16'h000a, mult);
      foreach (ra[i]) begin
         rd(ra[i], v);
         chk("reg", rv[i], v);
      end
      rd(12'h123, v);
      chk("unmapped", 16'h0000, v);
      $display("test reset done");
      for (int i = 0; i < 5; i++) begin
         m = 2 * (qw[i] ? 16 : 8) * 10 / 8 / ql[i];
         setup(qc[i], qw[i], qd[i], m);
         chk("link_up", 16'h0001, up);
         chk("lanes", 16'((1 << ql[i]) - 1), lanes);
         chk("mult", 16'(m), mult);
         chk("llr", 16'(m * 1000 / qd[i] < 6250), llr);
         si <= 16'($random(seed));
         sq <= 16'($random(seed));
         repeat (3 * qd[i] + 6) @(posedge ref_clk_in);
         chk("conv0", si, rx_i);
         chk("conv1", sq, rx_q);
         chk("frame_gap", 16'(qd[i]), 16'(gap));
         rd(12'h56f, v);
         chk("status", 16'h0080, v);
      end
      $display("test configs done");
      lock <= 1'b0;
      wr(12'h56f, 8'hff);
      rd(12'h56f, v);
      chk("status", 16'h0000, v);
      lock <= 1'b1;
      wr(12'h570, 8'h49);
      chk("lanes", 16'h0001, lanes);
      s0 = stray;
      wr(12'h571, 8'h01);
      @(posedge ref_clk_in);
      chk("link_up", 16'h0000, up);
      chk("lanes", 16'h0000, lanes);
      repeat (20) @(posedge ref_clk_in);
      chk("stray", 16'(s0), 16'(stray));
      wr(12'h571, 8'h00);
      @(posedge ref_clk_in);
      chk("lanes", 16'h0003, lanes);
      $display("test power done");
      for (int i = 0; i < 4; i++) begin
         wr(12'h571, 8'h01);
         wr(ea[i], eb[i]);
         wr(12'h571, 8'h00);
         repeat (2) @(posedge ref_clk_in);
         chk("link_up", 16'h0000, up);
         rd(12'h56f, v);
         chk("status", 16'(ee[i]), v);
         wr(ea[i], ec[i]);
         @(posedge ref_clk_in);
         chk("link_up", 16'h0001, up);
      end
      $display("test refusals done");
      wr(12'h571, 8'h01);
      wr(12'h58d, 8'h00);
      wr(12'h58c, 8'h08);
      wr(12'h570, 8'h48);
      wr(12'h58b, 8'h0f);
      wr(12'h571, 8'h00);
      repeat (2) @(posedge ref_clk_in);
      chk("link_up", 16'h0000, up);
      rd(12'h56f, v);
      chk("status", 16'h0003, v);
      wr(12'h571, 8'h01);
      wr(12'h58d, 8'h01);
      wr(12'h58c, 8'h0d);
      wr(12'h58b, 8'h1f);
      wr(12'h200, 8'h03);
      wr(12'h570, 8'h9a);
      wr(12'h571, 8'h00);
      repeat (2) @(posedge ref_clk_in);
      chk("link_up", 16'h0001, up);
      chk("lanes", 16'h000f, lanes);
      chk("mult", 16'(8 * 16 * 10 / 8 / 4), mult);
      chk("llr", 16'(40 * 1000 / 8 < 6250), llr);
      $display("test modes done");
      conclude();
   end
endmodule
